// file: rsf_consts.svh
// Constants for the ramp status and event flag block
`ifndef RSF_CONSTS_SVH
`define RSF_CONSTS_SVH
`define RSF_ADDR_W 7
`define RSF_OFS_STAT 7'h60
`define RSF_OFS_MASK 7'h70
`define RSF_OFS_CTRL 7'h71
`define RSF_BIT_VSTOP_R 15
`define RSF_BIT_VSTOP_L 14
`define RSF_BIT_STALL 13
`define RSF_BIT_SECOND 12
`define RSF_BIT_WAIT 11
`define RSF_BIT_VZERO 10
`define RSF_BIT_POS 9
`define RSF_BIT_VEL 8
`define RSF_BIT_EV_POS 7
`define RSF_BIT_EV_SG 6
`define RSF_BIT_EV_R 5
`define RSF_BIT_EV_L 4
`define RSF_CTRL_SG_EN 0
`define RSF_CTRL_HALT_EN 1
`define RSF_CTRL_STOPR_EN 2
`define RSF_CTRL_STOPL_EN 3
`define RSF_CTRL_SOFT 4
`define RSF_EV_MASK_RST 32'h000000F0
`define RSF_CTRL_RST 32'h0000000F
`endif

// file: rsf_pkg.sv
// Types shared by the ramp status flag block
package rsf_pkg;
  typedef struct packed {
    logic [31:0] actual_position;
    logic [31:0] target_position;
    logic [31:0] actual_velocity;
    logic [31:0] target_velocity;
  } rsf_motion_s;
  typedef struct packed {
    logic stall_in;
    logic reversal;
    logic wait_active;
    logic stop_r_sw;
    logic stop_l_sw;
    logic vstop_r;
    logic vstop_l;
    logic hold_mode;
    logic move_left;
    logic move_right;
    logic motor_moving_r;
    logic motor_moving_l;
  } rsf_events_s;
  typedef enum logic [1:0] {
    RSF_IDLE = 2'b00,
    RSF_ACTIVE = 2'b01,
    RSF_DRAIN = 2'b10
  } rsf_stop_e;
endpackage

// file: rsf_stop_latch.sv
// One side's stop event latch
`timescale 1ns/1ps
`include "rsf_consts.svh"
module rsf_stop_latch (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic cond_in,
  input wire logic enable_in,
  input wire logic soft_in,
  input wire logic release_in,
  input wire logic moving_in,
  output logic event_out
);
  typedef struct packed {
    rsf_pkg::rsf_stop_e st;
  } rsf_sl_s;
  rsf_sl_s r;
  rsf_sl_s next_r;
  always_comb
  begin
    next_r = r;
    case (r.st)
      rsf_pkg::RSF_IDLE:
        // Hold or an opposite move keeps the latch from re-arming on a switch still pressed
        if (cond_in && enable_in && !release_in)
          next_r.st = rsf_pkg::RSF_ACTIVE;
      rsf_pkg::RSF_ACTIVE:
        if (!enable_in)
          next_r.st = rsf_pkg::RSF_IDLE;
        else if (release_in)
          next_r.st = soft_in ? rsf_pkg::RSF_DRAIN : rsf_pkg::RSF_IDLE;
      rsf_pkg::RSF_DRAIN:
        // Decel into the switch must finish before the condition lets go
        if (!enable_in)
          next_r.st = rsf_pkg::RSF_IDLE;
        else if (!moving_in)
          next_r.st = rsf_pkg::RSF_IDLE;
      default:
        next_r.st = rsf_pkg::RSF_IDLE;
    endcase
  end
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      r <= '{st: rsf_pkg::RSF_IDLE};
    else
      r <= next_r;
  end
  assign event_out = (r.st != rsf_pkg::RSF_IDLE);
endmodule

// file: rsf_cmp.sv
// Equality compares for the ramp status bits
`timescale 1ns/1ps
module rsf_cmp (
  input wire logic clk_in,
  input wire logic resetn_in,
  input rsf_pkg::rsf_motion_s motion_in,
  output logic pos_match_out,
  output logic vel_match_out,
  output logic vzero_out
);
  function automatic logic eq32(input logic [31:0] a, input logic [31:0] b);
    eq32 = (a == b);
  endfunction
  // Combinational so the flags track the counters in the same cycle
  always_comb
  begin
    pos_match_out = eq32(motion_in.actual_position, motion_in.target_position);
    vel_match_out = eq32(motion_in.actual_velocity, motion_in.target_velocity);
    vzero_out = eq32(motion_in.actual_velocity, 32'h00000000);
  end
endmodule

// file: rsf_top.sv
// Ramp status and event flag register bank for one axis
// How it works
// - Bit 13 shows the stall input while stall detection is enabled.
// - Bit 12 latches a direction reversal and clears on a written one.
// - Bit 11 is high during the post-stop wait period.
// - Bit 10 is high exactly while actual velocity is zero.
// - Bit 9 is high exactly while actual position equals target position.
// - Bit 8 is high exactly while actual velocity equals target velocity.
// - Bit 7 latches on a rising position match and clears on a written one.
// - The interrupt is the OR of the unmasked event bits 7 to 4.
// - Bit 6 latches a stall stop; a written one clears it and releases the stall halt.
// - Bit 5 sets on a real or virtual right stop condition and holds until hold mode or a left move.
// - Bit 4 sets on a real or virtual left stop condition and holds until hold mode or a right move.
// - In soft stop mode the stop condition lasts until deceleration ends.
// - Disabling a stop switch clears its event while motion continues.
// - Bits 15 and 14 show the virtual right and left limits.
`timescale 1ns/1ps
`include "rsf_consts.svh"
module rsf_top (
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic [`RSF_ADDR_W-1:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input rsf_pkg::rsf_motion_s MOTION_IN,
  input rsf_pkg::rsf_events_s EVENTS_IN,
  output logic [31:0] RDATA_OUT,
  output logic STALL_HALT_OUT,
  output logic IRQ_OUT
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic second_move;
    logic ev_pos;
    logic ev_sg;
    logic pos_d;
    logic [31:0] mask;
    logic [31:0] ctrl;
    logic [31:0] rdata;
  } rsf_state_s;
  rsf_state_s r;
  rsf_state_s next_r;
  logic pos_match;
  logic vel_match;
  logic vzero;
  logic ev_r;
  logic ev_l;
  logic [31:0] stat;
  logic wr_stat;
  logic stall_flag;

  // ----------------------------------------
  // Compares and stop latches
  // ----------------------------------------
  rsf_cmp u_cmp (
    .clk_in(CLK_IN),
    .resetn_in(RESETN_IN),
    .motion_in(MOTION_IN),
    .pos_match_out(pos_match),
    .vel_match_out(vel_match),
    .vzero_out(vzero)
  );
  rsf_stop_latch u_stop_r (
    .clk_in(CLK_IN),
    .resetn_in(RESETN_IN),
    .cond_in(EVENTS_IN.stop_r_sw | EVENTS_IN.vstop_r),
    .enable_in(r.ctrl[`RSF_CTRL_STOPR_EN]),
    .soft_in(r.ctrl[`RSF_CTRL_SOFT]),
    .release_in(EVENTS_IN.hold_mode | EVENTS_IN.move_left),
    .moving_in(EVENTS_IN.motor_moving_r),
    .event_out(ev_r)
  );
  rsf_stop_latch u_stop_l (
    .clk_in(CLK_IN),
    .resetn_in(RESETN_IN),
    .cond_in(EVENTS_IN.stop_l_sw | EVENTS_IN.vstop_l),
    .enable_in(r.ctrl[`RSF_CTRL_STOPL_EN]),
    .soft_in(r.ctrl[`RSF_CTRL_SOFT]),
    .release_in(EVENTS_IN.hold_mode | EVENTS_IN.move_right),
    .moving_in(EVENTS_IN.motor_moving_l),
    .event_out(ev_l)
  );

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  assign stall_flag = EVENTS_IN.stall_in & r.ctrl[`RSF_CTRL_SG_EN];
  always_comb
  begin
    stat = 32'h00000000;
    stat[`RSF_BIT_VSTOP_R] = EVENTS_IN.vstop_r;
    stat[`RSF_BIT_VSTOP_L] = EVENTS_IN.vstop_l;
    stat[`RSF_BIT_STALL] = stall_flag;
    stat[`RSF_BIT_SECOND] = r.second_move;
    stat[`RSF_BIT_WAIT] = EVENTS_IN.wait_active;
    stat[`RSF_BIT_VZERO] = vzero;
    stat[`RSF_BIT_POS] = pos_match;
    stat[`RSF_BIT_VEL] = vel_match;
    stat[`RSF_BIT_EV_POS] = r.ev_pos;
    stat[`RSF_BIT_EV_SG] = r.ev_sg;
    stat[`RSF_BIT_EV_R] = ev_r;
    stat[`RSF_BIT_EV_L] = ev_l;
  end
  assign wr_stat = WR_IN && (ADDR_IN == `RSF_OFS_STAT);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Set beats clear in the same cycle so no event is lost
  always_comb
  begin
    next_r = r;
    next_r.pos_d = pos_match;
    if (wr_stat && WDATA_IN[`RSF_BIT_SECOND])
      next_r.second_move = 1'b0;
    if (EVENTS_IN.reversal)
      next_r.second_move = 1'b1;
    if (wr_stat && WDATA_IN[`RSF_BIT_EV_POS])
      next_r.ev_pos = 1'b0;
    if (pos_match && !r.pos_d)
      next_r.ev_pos = 1'b1;
    if (wr_stat && WDATA_IN[`RSF_BIT_EV_SG])
      next_r.ev_sg = 1'b0;
    // Stall stop only latches when halting on stall is enabled
    if (stall_flag && r.ctrl[`RSF_CTRL_HALT_EN])
      next_r.ev_sg = 1'b1;
    if (WR_IN && ADDR_IN == `RSF_OFS_MASK)
      next_r.mask = WDATA_IN;
    if (WR_IN && ADDR_IN == `RSF_OFS_CTRL)
      next_r.ctrl = WDATA_IN;
    next_r.rdata = 32'h00000000;
    if (RD_IN)
    begin
      case (ADDR_IN)
        `RSF_OFS_STAT: next_r.rdata = stat;
        `RSF_OFS_MASK: next_r.rdata = r.mask;
        `RSF_OFS_CTRL: next_r.rdata = r.ctrl;
        default: next_r.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      r.second_move <= 1'b0;
      r.ev_pos <= 1'b0;
      r.ev_sg <= 1'b0;
      r.pos_d <= 1'b0;
      r.mask <= `RSF_EV_MASK_RST;
      r.ctrl <= `RSF_CTRL_RST;
      r.rdata <= 32'h00000000;
    end
    else
      r <= next_r;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign RDATA_OUT = r.rdata;
  assign STALL_HALT_OUT = r.ev_sg;
  // Only bits 7..4 can raise the line, whatever the mask holds
  assign IRQ_OUT = |(stat & r.mask & `RSF_EV_MASK_RST);
endmodule

// file: rsf_properties.sv
// Port checker for the ramp status flag block
`timescale 1ns/1ps
`include "rsf_consts.svh"
module rsf_properties (
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic [`RSF_ADDR_W-1:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input rsf_pkg::rsf_motion_s MOTION_IN,
  input rsf_pkg::rsf_events_s EVENTS_IN,
  input wire logic [31:0] RDATA_OUT,
  input wire logic STALL_HALT_OUT,
  input wire logic IRQ_OUT
);
  wire logic rs = RD_IN && ADDR_IN == `RSF_OFS_STAT;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  AST_VZERO: assert property (rs && $stable(MOTION_IN) |=>
    RDATA_OUT[10] == ($past(MOTION_IN.actual_velocity) == 32'h0)) else $error("vzero bit");
  AST_POS: assert property (rs && $stable(MOTION_IN) |=> RDATA_OUT[9] ==
    ($past(MOTION_IN.actual_position) == $past(MOTION_IN.target_position))) else $error("pos");
  AST_VEL: assert property (rs && $stable(MOTION_IN) |=> RDATA_OUT[8] ==
    ($past(MOTION_IN.actual_velocity) == $past(MOTION_IN.target_velocity))) else $error("vel");
  AST_LIMITS: assert property (rs && $stable(EVENTS_IN) |=>
    RDATA_OUT[15] == $past(EVENTS_IN.vstop_r) && RDATA_OUT[14] == $past(EVENTS_IN.vstop_l)
    && RDATA_OUT[11] == $past(EVENTS_IN.wait_active)) else $error("limit bits");
  AST_HALT: assert property (rs |=> RDATA_OUT[6] == $past(STALL_HALT_OUT))
    else $error("halt bit");
  AST_IRQ_SRC: assert property (rs && IRQ_OUT |=> RDATA_OUT[7:4] != 4'h0)
    else $error("irq source");
  AST_IRQ_MASK: assert property (WR_IN && ADDR_IN == `RSF_OFS_MASK &&
    WDATA_IN[7:4] == 4'h0 |=> !IRQ_OUT) else $error("irq mask");
  AST_IRQ_RST: assert property ($rose(RESETN_IN) |-> !IRQ_OUT) else $error("irq reset");
  AST_UNMAP: assert property (RD_IN && !(ADDR_IN inside {`RSF_OFS_STAT, `RSF_OFS_MASK,
    `RSF_OFS_CTRL}) |=> RDATA_OUT == 32'h0) else $error("unmapped");
endmodule
bind rsf_top rsf_properties u_props (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .ADDR_IN(ADDR_IN),
  .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .MOTION_IN(MOTION_IN),
  .EVENTS_IN(EVENTS_IN), .RDATA_OUT(RDATA_OUT), .STALL_HALT_OUT(STALL_HALT_OUT),
  .IRQ_OUT(IRQ_OUT));

// file: ramp_status_event_flags_tb_top.sv
// Self-checking bench of the ramp status flag block
`timescale 1ns/1ps
`include "rsf_consts.svh"
module ramp_status_event_flags_tb_top;
  logic clk;
  logic rst_n;
  logic [`RSF_ADDR_W-1:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  rsf_pkg::rsf_motion_s mo;
  rsf_pkg::rsf_events_s ev;
  logic [31:0] rdata;
  logic halt;
  logic irq;
  logic [31:0] d;
  logic [15:0] r;
  int err_count;
  int comparisons;
  rsf_top dut (.CLK_IN(clk), .RESETN_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
    .RD_IN(rd), .MOTION_IN(mo), .EVENTS_IN(ev), .RDATA_OUT(rdata), .STALL_HALT_OUT(halt),
    .IRQ_OUT(irq));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // Gap cycle after each strobe keeps one driver assignment per time step
  task automatic wreg(input logic [6:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [6:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    // Read data stand one cycle only; taken at the edge that ends it
    @(posedge clk);
    d = rdata;
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    err_count++;
    give_verdict();
  end
  initial
  begin
    rst_n = 1'b0;
    addr = 7'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    mo = '0;
    ev = '0;
    r = 16'h005C;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rreg(`RSF_OFS_MASK);
    chk("mask", d, `RSF_EV_MASK_RST);
    rreg(7'h05);
    chk("unmapped", d, 32'h0);
    for (int i = 0; i < 40; i++)
    begin
      r = lfsr(r);
      mo <= {30'h0, r[1:0], 30'h0, r[3:2], 30'h0, r[5:4], 30'h0, r[7:6]};
      ev <= {r[8], 1'b0, r[12], r[9], r[14], r[13], r[10], r[11], 4'h0};
      repeat (2) @(posedge clk);
      rreg(`RSF_OFS_STAT);
      chk("levels", d & 32'h0000EF00, {16'h0, ev.vstop_r, ev.vstop_l, ev.stall_in,
        1'b0, ev.wait_active, mo.actual_velocity == 32'h0,
        mo.actual_position == mo.target_position,
        mo.actual_velocity == mo.target_velocity, 8'h0});
    end
    // Hold mode drops leftover stop latches; a written one drops the others
    ev <= 12'h010;
    mo <= 128'h0;
    repeat (3) @(posedge clk);
    wreg(`RSF_OFS_STAT, 32'h0000_0000);
    rreg(`RSF_OFS_STAT);
    chk("pos event", d[7], 1'b1);
    wreg(`RSF_OFS_STAT, 32'h0000_10F0);
    rreg(`RSF_OFS_STAT);
    chk("cleared", {halt, irq, d[12], d[7:4]}, 7'h00);
    ev <= 12'h400;
    rreg(`RSF_OFS_STAT);
    chk("reversal", d[13:12], 2'h1);
    // Set beats a clear that lands in the same cycle
    wreg(`RSF_OFS_STAT, 32'h0000_1000);
    rreg(`RSF_OFS_STAT);
    chk("set wins", d[12], 1'b1);
    ev <= 12'h000;
    wreg(`RSF_OFS_STAT, 32'h0000_1000);
    rreg(`RSF_OFS_STAT);
    chk("second clr", d[12], 1'b0);
    ev <= 12'h800;
    rreg(`RSF_OFS_STAT);
    chk("halt", {halt, d[13], d[6], irq}, 4'hF);
    ev <= 12'h000;
    wreg(`RSF_OFS_STAT, 32'h0000_0040);
    rreg(`RSF_OFS_STAT);
    chk("halt clear", {halt, d[6], irq}, 3'h0);
    // A one-cycle stall that polling cannot see still leaves the latched event
    ev <= 12'h800;
    @(posedge clk);
    ev <= 12'h000;
    rreg(`RSF_OFS_STAT);
    chk("short stall", {d[13], d[6]}, 2'h1);
    wreg(`RSF_OFS_STAT, 32'h0000_0040);
    ev <= 12'h100;
    rreg(`RSF_OFS_STAT);
    chk("right", {halt, d[6:5], irq}, 4'h3);
    ev <= 12'h108;
    rreg(`RSF_OFS_STAT);
    chk("opposite", {d[5], irq}, 2'h0);
    ev <= 12'h100;
    wreg(`RSF_OFS_MASK, 32'h0);
    @(posedge clk);
    chk("masked", irq, 1'b0);
    rreg(`RSF_OFS_STAT);
    chk("still right", d[5], 1'b1);
    wreg(`RSF_OFS_CTRL, 32'h0000_001B);
    rreg(`RSF_OFS_STAT);
    chk("disabled", d[5], 1'b0);
    ev <= 12'h0C1;
    repeat (3) @(posedge clk);
    ev <= 12'h0D1;
    rreg(`RSF_OFS_STAT);
    chk("soft", d[4], 1'b1);
    ev <= 12'h0D0;
    rreg(`RSF_OFS_STAT);
    chk("soft end", d[4], 1'b0);
    wreg(`RSF_OFS_CTRL, 32'h0);
    ev <= 12'h800;
    rreg(`RSF_OFS_STAT);
    chk("sg off", {d[13], d[6], halt}, 3'h0);
    give_verdict();
  end
endmodule
